/* dv/cpu_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module cpu_core_model (
    // Clock and bench control
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       ie_cmd,
    input  wire logic [3:0] ack_dly,
    // Controller side
    input  wire logic       irq_request,
    output logic            cpu_global_ie,
    output logic            irq_ack
);
    logic [3:0] wait_reg;
    // Flag is forced clear while reset is held
    assign cpu_global_ie = ie_cmd & rst_n;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {irq_ack, wait_reg} <= 5'h00;
        end else if (irq_request && cpu_global_ie && !irq_ack) begin
            irq_ack  <= (wait_reg >= ack_dly);
            wait_reg <= (wait_reg >= ack_dly) ? 4'h0 : wait_reg + 4'h1;
        end else begin
            irq_ack <= 1'b0;
        end
    end
endmodule : cpu_core_model
`default_nettype wire

/* dv/tb_priority_interrupt_controller.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_priority_interrupt_controller;
    import irq_pkg::*;
    logic clk = 0, rst_n = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic ie = 0, awready, wready, bvalid, arready, rvalid, irq_req, irq_ack, gie;
    logic [11:0] awaddr = 12'h0, araddr = 12'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [1:0]  rresp, bresp;
    logic [14:0] evt = 15'h0, pend = 15'h0;
    logic [7:0]  gpio = 8'h0, gm = 8'h0, bm = 8'h0;
    logic [3:0]  dly = 4'h0;
    logic [15:0] ack_vec;
    int          err_count = 0, total_checks = 0;
    priority_interrupt_controller u_priority_interrupt_controller (.clk(clk), .rst_n(rst_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .supply_monitor_event(evt[0]), .digital_block_event(evt[8:1]),
        .analog_column_event(evt[12:9]), .sleep_timer_event(evt[14]), .gpio_pin_in(gpio),
        .cpu_global_ie(gie), .irq_ack(irq_ack), .irq_request(irq_req), .ack_vector_addr(ack_vec));
    cpu_core_model u_cpu_core_model (.clk(clk), .rst_n(rst_n), .ie_cmd(ie), .ack_dly(dly),
        .irq_request(irq_req), .cpu_global_ie(gie), .irq_ack(irq_ack));
    initial forever #12.5 clk = ~clk;
    task automatic give_verdict();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic tmo();
        err_count++;
        $display("ERROR %0t wait ran out", $time);
        give_verdict();
    endtask : tmo
    function automatic logic [7:0] mvec();
        logic [14:0] m;
        logic [7:0]  v;
        m = pend & {gm[6:1], bm, gm[0]};
        v = VEC_NONE;
        for (int i = 14; i >= 0; i--) if (m[i]) v = 8'(4 * (i + 1));
        return v;
    endfunction : mvec
    task automatic axw(input logic [11:0] a, input logic [7:0] d);
        logic ta, tw, tb;
        int   n;
        {n, tb} = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h0, d};
        {awvalid, wvalid, bready} <= 3'b111;
        while (!tb) begin
            @(negedge clk);
            {ta, tw, tb} = {awvalid & awready, wvalid & wready, bvalid};
            if (tb) chk(32'(bresp), 32'(RESP_OKAY));
            if (++n > 20) tmo();
            @(posedge clk);
            {awvalid, wvalid, bready} <= {awvalid & !ta, wvalid & !tw, !tb};
        end
    endtask : axw
    task automatic axr(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er = RESP_OKAY);
        logic dn;
        int   n;
        {n, dn} = 0;
        @(posedge clk);
        araddr <= a;
        {arvalid, rready} <= 2'b11;
        while (!dn) begin
            @(negedge clk);
            dn = rvalid;
            if (dn) chk(rdata, e);
            if (dn) chk(32'(rresp), 32'(er));
            if (++n > 20) tmo();
            @(posedge clk);
            {arvalid, rready} <= {arvalid & !arready, !dn};
        end
    endtask : axr
    task automatic fire(input logic [14:0] e);
        @(posedge clk);
        evt <= e;
        @(posedge clk);
        evt <= 15'h0;
        pend = pend | e;
    endtask : fire
    task automatic take();
        logic [7:0] v;
        int         n;
        v = mvec();
        n = 0;
        do begin @(negedge clk); if (++n > 40) tmo(); end while (!irq_ack);
        @(negedge clk);
        chk(32'(ack_vec), 32'(v));
        pend[v[7:2] - 6'h1] = 1'b0;
    endtask : take
    initial begin
        void'($urandom(32'h8C4F1365));
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        axr(GEN_MASK_ADDR, 32'h0);
        axr(BLK_MASK_ADDR, 32'h0);
        axr(VECTOR_ADDR, 32'h0);
        axr(12'h000, 32'h0, RESP_SLVERR);
        axw(GEN_MASK_ADDR, 8'hFF);
        gm = 8'h7F;
        axr(GEN_MASK_ADDR, 32'h7F);
        bm = 8'($urandom);
        axw(BLK_MASK_ADDR, bm);
        axr(BLK_MASK_ADDR, {24'h0, bm});
        bm = 8'hFF;
        axw(BLK_MASK_ADDR, bm);
        for (int i = 0; i < 15; i++) begin
            if (i != IDX_PIN_GROUP) fire(15'h1 << i);
            axr(VECTOR_ADDR, {24'h0, mvec()});
            axw(VECTOR_ADDR, 8'($urandom));
            pend = 15'h0;
            axr(VECTOR_ADDR, 32'h0);
        end
        for (int k = 0; k < 8; k++) begin
            gm = 8'($urandom) & 8'h7F;
            bm = 8'($urandom);
            axw(GEN_MASK_ADDR, gm);
            axw(BLK_MASK_ADDR, bm);
            fire(15'($urandom) & 15'h5FFF);
            axr(VECTOR_ADDR, {24'h0, mvec()});
            axw(VECTOR_ADDR, 8'h00);
            pend = 15'h0;
        end
        {gm, bm} = 16'h7FFF;
        axw(GEN_MASK_ADDR, gm);
        axw(BLK_MASK_ADDR, bm);
        fire(15'h0006);
        repeat (3) @(negedge clk);
        chk(32'(irq_req), 32'h0);
        @(posedge clk);
        dly <= 4'($urandom % 4);
        ie <= 1'b1;
        take();
        take();
        axw(PIN_ENABLE_ADDR, 8'hFF);
        ie <= 1'b0;
        for (int t = 0; t < 5; t++) begin
            axw(PIN_INPUT_OK_ADDR, t[2] ? 8'h00 : 8'hFF);
            axw(EDGE_LOW_ADDR, 8'(t[0] | t[2]));
            axw(EDGE_HIGH_ADDR, 8'(t[1]));
            gpio <= 8'h01;
            repeat (8) @(posedge clk);
            pend[IDX_PIN_GROUP] = t[0];
            axr(VECTOR_ADDR, {24'h0, mvec()});
            gpio <= 8'h00;
            repeat (4) @(posedge clk);
            axr(PORT_DATA_ADDR, 32'h0);
            axw(VECTOR_ADDR, 8'h00);
            pend = 15'h0;
        end
        give_verdict();
    end
endmodule : tb_priority_interrupt_controller
`default_nettype wire

/* verilog/irq_pkg.sv */
package irq_pkg;

    // ------------------------------------------------------------------
    // Source layout
    // ------------------------------------------------------------------
    localparam int NUM_SRC       = 15;
    localparam int NUM_BLOCKS    = 8;
    localparam int NUM_COLS      = 4;
    localparam int IDX_SUPPLY    = 0;
    localparam int IDX_BLK0      = 1;
    localparam int IDX_COL0      = 9;
    localparam int IDX_PIN_GROUP = 13;
    localparam int IDX_SLEEP     = 14;

    // ------------------------------------------------------------------
    // Vector table
    // ------------------------------------------------------------------
    localparam logic [7:0]  VEC_BASE   = 8'h04;
    localparam logic [7:0]  VEC_STEP   = 8'h04;
    localparam logic [7:0]  VEC_NONE   = 8'h00;
    localparam logic [15:0] PROG_START = 16'h0040;

    // ------------------------------------------------------------------
    // General mask field positions
    // ------------------------------------------------------------------
    localparam int GEN_SUPPLY_BIT = 0;
    localparam int GEN_COL0_BIT   = 1;
    localparam int GEN_PIN_BIT    = 5;
    localparam int GEN_SLEEP_BIT  = 6;
    localparam int GEN_MASK_W     = 7;

    // ------------------------------------------------------------------
    // Register indices and byte addresses
    // ------------------------------------------------------------------
    localparam int          ADDR_W            = 12;
    localparam logic [11:0] GEN_MASK_IDX      = 12'h0E0;
    localparam logic [11:0] BLK_MASK_IDX      = 12'h0E1;
    localparam logic [11:0] VECTOR_IDX        = 12'h0E2;
    localparam logic [11:0] PIN_ENABLE_IDX    = 12'h0E4;
    localparam logic [11:0] EDGE_LOW_IDX      = 12'h0E5;
    localparam logic [11:0] EDGE_HIGH_IDX     = 12'h0E6;
    localparam logic [11:0] PIN_INPUT_OK_IDX  = 12'h0E7;
    localparam logic [11:0] PORT_DATA_IDX     = 12'h0E8;
    localparam logic [11:0] PENDING_IDX       = 12'h0E9;
    localparam logic [11:0] GEN_MASK_ADDR     = GEN_MASK_IDX << 2;
    localparam logic [11:0] BLK_MASK_ADDR     = BLK_MASK_IDX << 2;
    localparam logic [11:0] VECTOR_ADDR       = VECTOR_IDX << 2;
    localparam logic [11:0] PIN_ENABLE_ADDR   = PIN_ENABLE_IDX << 2;
    localparam logic [11:0] EDGE_LOW_ADDR     = EDGE_LOW_IDX << 2;
    localparam logic [11:0] EDGE_HIGH_ADDR    = EDGE_HIGH_IDX << 2;
    localparam logic [11:0] PIN_INPUT_OK_ADDR = PIN_INPUT_OK_IDX << 2;
    localparam logic [11:0] PORT_DATA_ADDR    = PORT_DATA_IDX << 2;
    localparam logic [11:0] PENDING_ADDR      = PENDING_IDX << 2;

    localparam logic [7:0]  REG8_RESET  = 8'h00;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {EDGE_NONE, EDGE_RISE, EDGE_FALL, EDGE_CHANGE} edge_type_e;

endpackage : irq_pkg

/* verilog/pin_cfg_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface pin_cfg_if #(parameter int NUM_PINS = 8);
    logic [NUM_PINS-1:0] pin_level;
    logic [NUM_PINS-1:0] port_pin_irq_enable;
    logic [NUM_PINS-1:0] port_edge_type_low;
    logic [NUM_PINS-1:0] port_edge_type_high;
    logic [NUM_PINS-1:0] pin_input_ok;
    logic                port_read;
    logic [NUM_PINS-1:0] pin_irq_output;

    modport ctrl (output pin_level, port_pin_irq_enable, port_edge_type_low,
                  output port_edge_type_high, pin_input_ok, port_read,
                  input  pin_irq_output);
    modport detect (input  pin_level, port_pin_irq_enable, port_edge_type_low,
                    input  port_edge_type_high, pin_input_ok, port_read,
                    output pin_irq_output);
endinterface : pin_cfg_if
`default_nettype wire

/* verilog/pin_irq_detect.sv */
`timescale 1ns/1ps
`default_nettype none
module pin_irq_detect #(
    parameter int NUM_PINS = 8
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Pin configuration and state
    pin_cfg_if.detect pins
);
    import irq_pkg::*;

    logic [NUM_PINS-1:0] level_d_reg;
    logic [NUM_PINS-1:0] captured_reg;
    logic [NUM_PINS-1:0] edge_seen_reg;

    // ------------------------------------------------------------------
    // Level history and read capture
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            level_d_reg  <= '0;
            captured_reg <= '0;
        end else begin
            level_d_reg <= pins.pin_level;
            if (pins.port_read) begin
                captured_reg <= pins.pin_level; // [RULE_11]
            end
        end
    end

    // ------------------------------------------------------------------
    // Per-pin detection
    // ------------------------------------------------------------------
    for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
        edge_type_e kind;
        logic       active;
        logic       hit;
        assign kind   = edge_type_e'({pins.port_edge_type_high[i], pins.port_edge_type_low[i]});
        assign active = pins.port_pin_irq_enable[i] && pins.pin_input_ok[i]; // [RULE_09] [RULE_13]
        always_comb begin
            unique case (kind)
                EDGE_NONE:   hit = 1'b0; // [RULE_10]
                EDGE_RISE:   hit = pins.pin_level[i] && !level_d_reg[i];
                EDGE_FALL:   hit = !pins.pin_level[i] && level_d_reg[i];
                EDGE_CHANGE: hit = 1'b0;
            endcase
        end
        // Edge catches stay up until the port is read; a new edge wins
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                edge_seen_reg[i] <= 1'b0;
            end else if (!active || kind == EDGE_NONE || kind == EDGE_CHANGE) begin
                edge_seen_reg[i] <= 1'b0;
            end else if (hit) begin
                edge_seen_reg[i] <= 1'b1;
            end else if (pins.port_read) begin
                edge_seen_reg[i] <= 1'b0;
            end
        end
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                pins.pin_irq_output[i] <= 1'b0;
            end else if (kind == EDGE_CHANGE) begin
                pins.pin_irq_output[i] <= active && (pins.pin_level[i] != captured_reg[i]); // [RULE_11]
            end else begin
                pins.pin_irq_output[i] <= active && (edge_seen_reg[i] || hit); // [RULE_10]
            end
        end
    end

endmodule : pin_irq_detect
`default_nettype wire

/* verilog/priority_interrupt_controller.sv */
// Overview of operation
// RULE_01 - Fifteen sources, vectors 0x04 step 4, priorities 1-15
// RULE_02 - Slot order ends sleep timer; program at 0x40
// RULE_03 - Acknowledge loads program counter with serviced vector
// RULE_04 - General mask: supply, columns, pins, sleep; bit7 reserved
// RULE_05 - Block mask bit n enables digital block n
// RULE_06 - Vector register reads highest-priority pending vector
// RULE_07 - Any vector register write clears all pending
// RULE_08 - Pins share one flag, priority 14, 0x38
// RULE_09 - Pin irq needs group bit and pin enable
// RULE_10 - Two-bit pin detection type; 00 gives nothing
// RULE_11 - Change mode compares pin to level captured on read
// RULE_12 - Group flag set only on rising edge of OR
// RULE_13 - Pin interrupts only when pin acts as input
// RULE_14 - No request without processor global enable
// RULE_15 - Each digital block own line, enable, vector
// RULE_16 - Pending flop sticky until serviced, reset, vector write
// RULE_17 - Request needs mask bit and global enable
// RULE_18 - Lowest priority number serviced first
// RULE_19 - Reset clears both masks and global enable
// RULE_20 - Nothing pending reads vector zero
`timescale 1ns/1ps
`default_nettype none
module priority_interrupt_controller #(
    parameter int NUM_PINS = 8
) (
    // Clock and reset
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    // AXI4-Lite write address and data
    input  wire logic [irq_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                       s_axi_awvalid,
    output var  logic                       s_axi_awready,
    input  wire logic [31:0]                s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    input  wire logic                       s_axi_wvalid,
    output var  logic                       s_axi_wready,
    // AXI4-Lite write response
    output var  logic [1:0]                 s_axi_bresp,
    output var  logic                       s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    // AXI4-Lite read
    input  wire logic [irq_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                       s_axi_arvalid,
    output var  logic                       s_axi_arready,
    output var  logic [31:0]                s_axi_rdata,
    output var  logic [1:0]                 s_axi_rresp,
    output var  logic                       s_axi_rvalid,
    input  wire logic                       s_axi_rready,
    // Interrupt sources
    input  wire logic                       supply_monitor_event,
    input  wire logic [irq_pkg::NUM_BLOCKS-1:0] digital_block_event,
    input  wire logic [irq_pkg::NUM_COLS-1:0]   analog_column_event,
    input  wire logic                       sleep_timer_event,
    input  wire logic [NUM_PINS-1:0]        gpio_pin_in,
    // Processor side
    input  wire logic                       cpu_global_ie,
    input  wire logic                       irq_ack,
    output var  logic                       irq_request,
    output var  logic [15:0]                ack_vector_addr
);
    import irq_pkg::*;

    pin_cfg_if #(.NUM_PINS(NUM_PINS)) pins ();

    logic [GEN_MASK_W-1:0] general_irq_enable_mask;
    logic [7:0]            block_irq_enable_mask;
    logic [NUM_PINS-1:0]   port_pin_irq_enable;
    logic [NUM_PINS-1:0]   port_edge_type_low;
    logic [NUM_PINS-1:0]   port_edge_type_high;
    logic [NUM_PINS-1:0]   pin_input_ok_reg;
    logic [NUM_PINS-1:0]   pin_meta_reg;
    logic [NUM_PINS-1:0]   pin_sync_reg;
    logic [NUM_SRC-1:0]    pending_reg;
    logic [NUM_SRC-1:0]    src_mask;
    logic [NUM_SRC-1:0]    pend_en;
    logic [NUM_SRC-1:0]    set_vec;
    logic [NUM_SRC-1:0]    ack_clr;
    logic [7:0]            vec_now;
    logic                  pin_any;
    logic                  pin_any_d_reg;
    logic                  aw_held_reg;
    logic                  w_held_reg;
    logic [ADDR_W-1:0]     awaddr_reg;
    logic [31:0]           wdata_reg;
    logic                  wstrb0_reg;
    logic                  wr_fire;
    logic                  vec_wr;
    logic                  port_read;

    // ------------------------------------------------------------------
    // Pin synchroniser and detector
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta_reg <= '0;
            pin_sync_reg <= '0;
        end else begin
            pin_meta_reg <= gpio_pin_in;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    assign pins.pin_level           = pin_sync_reg;
    assign pins.port_pin_irq_enable = port_pin_irq_enable;
    assign pins.port_edge_type_low  = port_edge_type_low;
    assign pins.port_edge_type_high = port_edge_type_high;
    assign pins.pin_input_ok        = pin_input_ok_reg;
    assign pins.port_read           = port_read;

    pin_irq_detect #(.NUM_PINS(NUM_PINS)) u_pin_detect (
        .clk   (clk),
        .rst_n (rst_n),
        .pins  (pins.detect)
    );

    assign pin_any = general_irq_enable_mask[GEN_PIN_BIT] && (|pins.pin_irq_output); // [RULE_09] [RULE_12]

    // ------------------------------------------------------------------
    // Source events, masks and priority
    // ------------------------------------------------------------------
    always_comb begin
        set_vec                = '0;
        set_vec[IDX_SUPPLY]    = supply_monitor_event;
        set_vec[IDX_BLK0 +: NUM_BLOCKS] = digital_block_event; // [RULE_15]
        set_vec[IDX_COL0 +: NUM_COLS]   = analog_column_event;
        set_vec[IDX_PIN_GROUP] = pin_any && !pin_any_d_reg; // [RULE_08] [RULE_12]
        set_vec[IDX_SLEEP]     = sleep_timer_event; // [RULE_02]
    end

    always_comb begin
        src_mask                = '0;
        src_mask[IDX_SUPPLY]    = general_irq_enable_mask[GEN_SUPPLY_BIT]; // [RULE_04]
        src_mask[IDX_BLK0 +: NUM_BLOCKS] = block_irq_enable_mask; // [RULE_05]
        src_mask[IDX_COL0 +: NUM_COLS]   = general_irq_enable_mask[GEN_COL0_BIT +: NUM_COLS];
        src_mask[IDX_PIN_GROUP] = general_irq_enable_mask[GEN_PIN_BIT];
        src_mask[IDX_SLEEP]     = general_irq_enable_mask[GEN_SLEEP_BIT];
    end

    assign pend_en = pending_reg & src_mask; // [RULE_17]

    // Lowest index wins; nothing enabled gives vector zero
    always_comb begin
        vec_now = VEC_NONE; // [RULE_20]
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (pend_en[i]) begin
                vec_now = VEC_BASE + VEC_STEP * 8'(i); // [RULE_01] [RULE_18]
            end
        end
    end

    always_comb begin
        ack_clr = '0;
        if (irq_ack && vec_now != VEC_NONE) begin
            ack_clr[4'((vec_now - VEC_BASE) >> 2)] = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Pending flags
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pending_reg   <= '0;
            pin_any_d_reg <= 1'b0;
        end else begin
            pin_any_d_reg <= pin_any;
            if (vec_wr) begin
                pending_reg <= set_vec; // [RULE_07]
            end else begin
                pending_reg <= (pending_reg & ~ack_clr) | set_vec; // [RULE_16]
            end
        end
    end

    // ------------------------------------------------------------------
    // Processor request and acknowledge
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_request     <= 1'b0;
            ack_vector_addr <= '0;
        end else begin
            irq_request <= cpu_global_ie && (|(pend_en & ~ack_clr)); // [RULE_14] [RULE_17]
            if (irq_ack) begin
                ack_vector_addr <= {8'h00, vec_now}; // [RULE_03]
            end
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite write
    // ------------------------------------------------------------------
    assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
    assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
    assign vec_wr  = wr_fire && awaddr_reg == VECTOR_ADDR; // [RULE_07]

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_held_reg  <= 1'b0;
            w_held_reg   <= 1'b0;
            awaddr_reg   <= '0;
            wdata_reg    <= '0;
            wstrb0_reg   <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                awaddr_reg  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                wdata_reg  <= s_axi_wdata;
                wstrb0_reg <= s_axi_wstrb[0];
            end
            if (wr_fire) begin
                aw_held_reg  <= 1'b0;
                w_held_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                unique case (awaddr_reg)
                    GEN_MASK_ADDR, BLK_MASK_ADDR, VECTOR_ADDR, PIN_ENABLE_ADDR,
                    EDGE_LOW_ADDR, EDGE_HIGH_ADDR, PIN_INPUT_OK_ADDR,
                    PORT_DATA_ADDR, PENDING_ADDR: s_axi_bresp <= RESP_OKAY;
                    default: s_axi_bresp <= RESP_SLVERR;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            general_irq_enable_mask <= GEN_MASK_W'(REG8_RESET); // [RULE_19]
            block_irq_enable_mask   <= REG8_RESET; // [RULE_19]
            port_pin_irq_enable     <= '0;
            port_edge_type_low      <= '0;
            port_edge_type_high     <= '0;
            pin_input_ok_reg        <= '0;
        end else if (wr_fire && wstrb0_reg) begin
            unique case (awaddr_reg)
                GEN_MASK_ADDR:     general_irq_enable_mask <= wdata_reg[GEN_MASK_W-1:0];
                BLK_MASK_ADDR:     block_irq_enable_mask   <= wdata_reg[7:0];
                PIN_ENABLE_ADDR:   port_pin_irq_enable     <= wdata_reg[NUM_PINS-1:0];
                EDGE_LOW_ADDR:     port_edge_type_low      <= wdata_reg[NUM_PINS-1:0];
                EDGE_HIGH_ADDR:    port_edge_type_high     <= wdata_reg[NUM_PINS-1:0];
                PIN_INPUT_OK_ADDR: pin_input_ok_reg        <= wdata_reg[NUM_PINS-1:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite read
    // ------------------------------------------------------------------
    assign s_axi_arready = !s_axi_rvalid;
    assign port_read = s_axi_arvalid && s_axi_arready && s_axi_araddr == PORT_DATA_ADDR;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= RESP_OKAY;
            unique case (s_axi_araddr)
                GEN_MASK_ADDR:     s_axi_rdata <= 32'(general_irq_enable_mask);
                BLK_MASK_ADDR:     s_axi_rdata <= 32'(block_irq_enable_mask);
                VECTOR_ADDR:       s_axi_rdata <= 32'(vec_now); // [RULE_06]
                PIN_ENABLE_ADDR:   s_axi_rdata <= 32'(port_pin_irq_enable);
                EDGE_LOW_ADDR:     s_axi_rdata <= 32'(port_edge_type_low);
                EDGE_HIGH_ADDR:    s_axi_rdata <= 32'(port_edge_type_high);
                PIN_INPUT_OK_ADDR: s_axi_rdata <= 32'(pin_input_ok_reg);
                PORT_DATA_ADDR:    s_axi_rdata <= 32'(pin_sync_reg);
                PENDING_ADDR:      s_axi_rdata <= 32'(pending_reg);
                default: begin
                    s_axi_rdata <= '0;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_vec_range;
        vec_now != VEC_NONE |-> (16'(vec_now) < PROG_START) && (vec_now[1:0] == 2'b00);
    endproperty
    a_vec_range: assert property (p_vec_range) else $error("vector outside table"); // [RULE_01]

    property p_vec_prio;
        pend_en[IDX_SUPPLY] |-> vec_now == VEC_BASE;
    endproperty
    a_vec_prio: assert property (p_vec_prio) else $error("supply not first"); // [RULE_18]

    property p_vec_zero;
        pend_en == '0 |-> vec_now == VEC_NONE;
    endproperty
    a_vec_zero: assert property (p_vec_zero) else $error("idle vector not zero"); // [RULE_20]

    property p_clear_all;
        vec_wr && set_vec == '0 |=> pending_reg == '0;
    endproperty
    a_clear_all: assert property (p_clear_all) else $error("vector write left pending"); // [RULE_07]

    property p_req_gated;
        irq_request |-> $past(cpu_global_ie) && $past(|pend_en);
    endproperty
    a_req_gated: assert property (p_req_gated) else $error("request without enables"); // [RULE_14]

    property p_ack_load;
        irq_ack |=> ack_vector_addr == {8'h00, $past(vec_now)};
    endproperty
    a_ack_load: assert property (p_ack_load) else $error("ack vector wrong"); // [RULE_03]

    property p_sticky;
        !vec_wr && !irq_ack |=> (pending_reg & $past(pending_reg)) == $past(pending_reg);
    endproperty
    a_sticky: assert property (p_sticky) else $error("pending lost"); // [RULE_16]

    property p_group_edge;
        set_vec[IDX_PIN_GROUP] |-> pin_any && !$past(pin_any);
    endproperty
    a_group_edge: assert property (p_group_edge) else $error("group set without edge"); // [RULE_12]

    property p_block_set;
        digital_block_event[3] |=> pending_reg[IDX_BLK0 + 3];
    endproperty
    a_block_set: assert property (p_block_set) else $error("block event not held"); // [RULE_15]

    c_ack: cover property (irq_request ##[1:4] irq_ack);
    c_vec_clear: cover property (pending_reg != '0 ##1 vec_wr);
    c_pin_group: cover property (set_vec[IDX_PIN_GROUP]);
    c_two_pending: cover property (pend_en[IDX_SUPPLY] && pend_en[IDX_SLEEP]);

endmodule : priority_interrupt_controller
`default_nettype wire
